// ===== hw/misc_regs.sv
// Misc runtime register slice: pin edge status, force media change and
// floppy rate shadow, plus an interrupt status/clear/enable group.
// Assumes a single 100 MHz core_clk and a plain strobe register port.
//
// What this block does
// - Writing one to a bit of the edge status 5:0 clears it; zero does nothing.
// - Status bits 7:6 always read zero.
// - The register at 0x1d reads all zero.
// - Writing one sets a force media change bit; software never clears it.
// - A head step while drive zero or one is selected clears that drive's bit.
// - The media changed flag is select-and-force per drive ORed with the pin.
// - The rate shadow mirrors rate, write_select_a, power down and soft reset.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "misc_regs_defines.svh"

module misc_regs
    import misc_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // General pins watched for edges
    input wire logic gen_pin_twenty_one,
    input wire logic gen_pin_twenty_two,
    input wire logic gen_pin_forty_one,
    input wire logic gen_pin_forty_three,
    input wire logic gen_pin_sixty,
    input wire logic gen_pin_sixty_one,
    // Floppy drive pins
    input wire logic head_step_pulse_n,
    input wire logic drive_zero_select_n,
    input wire logic drive_one_select_n,
    input wire logic media_changed_in_n,
    // Floppy controller settings to shadow
    input wire logic [1:0] data_rate_sel,
    input wire logic [2:0] write_select_a,
    input wire logic power_down,
    input wire logic soft_reset,
    // Results
    output logic media_changed_flag,
    output logic irq
);

    pin_sync_if sif ();

    pin_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .raw({media_changed_in_n, drive_one_select_n, drive_zero_select_n,
              head_step_pulse_n, gen_pin_sixty_one, gen_pin_sixty,
              gen_pin_forty_three, gen_pin_forty_one, gen_pin_twenty_two,
              gen_pin_twenty_one}),
        .sif(sif)
    );

    logic [`EDGE_BITS-1:0] pin_edge;
    logic sel0;
    logic sel1;
    logic step_go;
    logic clr_fc0;
    logic clr_fc1;
    logic wr_sts;
    logic wr_fc;
    logic wr_iclr;
    logic wr_ien;
    logic [`EDGE_BITS-1:0] sts_q;
    logic [1:0] fc_q;
    logic [7:0] irq_sts_q;
    logic [7:0] irq_en_q;
    logic [7:0] irq_ev;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic mc_q;
    rate_shadow_t shadow;

    assign pin_edge = sif.chg[`EDGE_BITS-1:0];
    assign sel0 = ~sif.lvl[`SYNC_DS0];
    assign sel1 = ~sif.lvl[`SYNC_DS1];
    // A step is taken on the assertion of the active-low step line.
    assign step_go = sif.chg[`SYNC_STEP] & ~sif.lvl[`SYNC_STEP];
    assign clr_fc0 = step_go & sel0;
    assign clr_fc1 = step_go & sel1;

    assign wr_sts = reg_wr && (reg_addr == `OFF_EDGE_STS);
    assign wr_fc = reg_wr && (reg_addr == `OFF_FORCE_CHG);
    assign wr_iclr = reg_wr && (reg_addr == `OFF_IRQ_CLR);
    assign wr_ien = reg_wr && (reg_addr == `OFF_IRQ_EN);

    // Edge status: a new edge wins over a write-one clear in the same cycle.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sts_q <= `RST_EDGE_STS;
        end else begin
            sts_q <= (sts_q & ~(wr_sts ? reg_wdata[`EDGE_BITS-1:0]
                     : '0)) | pin_edge;
        end
    end

    // Force media change: software may only set; a step clears.
    // A software set in the same cycle as a step clear is kept.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fc_q <= `RST_FORCE_CHG;
        end else begin
            fc_q[0] <= (fc_q[0] & ~clr_fc0) | (wr_fc & reg_wdata[0]);
            fc_q[1] <= (fc_q[1] & ~clr_fc1) | (wr_fc & reg_wdata[1]);
        end
    end

    // Media changed indication, registered to keep the output glitch free.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mc_q <= 1'b0;
        end else begin
            mc_q <= (sel0 & fc_q[0]) | (sel1 & fc_q[1])
                    | ~sif.lvl[`SYNC_CHG];
        end
    end

    assign media_changed_flag = mc_q;

    // Interrupt events: pin edges and hardware clears of the force bits.
    assign irq_ev = {clr_fc1 & fc_q[1], clr_fc0 & fc_q[0], pin_edge};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_sts_q <= `RST_IRQ;
        end else begin
            irq_sts_q <= (irq_sts_q & ~(wr_iclr ? reg_wdata : 8'h00))
                         | irq_ev;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_en_q <= `RST_IRQ;
        end else if (wr_ien) begin
            irq_en_q <= reg_wdata;
        end
    end

    assign irq = |(irq_sts_q & irq_en_q);

    // The shadow has no storage of its own; the settings are mirrored live.
    always_comb begin
        shadow = '0;
        shadow.data_rate = data_rate_sel;
        shadow.write_select_a = write_select_a;
        shadow.power_down = power_down;
        shadow.soft_reset = soft_reset;
    end

    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            `OFF_EDGE_STS: rdata_d = {2'b00, sts_q};
            `OFF_RSVD_1D: rdata_d = 8'h00;
            `OFF_FORCE_CHG: rdata_d = {6'h00, fc_q};
            `OFF_RATE_SHADOW: rdata_d = shadow;
            `OFF_IRQ_STS: rdata_d = irq_sts_q;
            `OFF_IRQ_EN: rdata_d = irq_en_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data are valid only in the cycle after the strobe.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    a_w1c_clears: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_sts |=> (sts_q & $past(reg_wdata[`EDGE_BITS-1:0])
                    & ~$past(pin_edge)) == 6'h00)
        else $error("written status bit did not clear");

    a_w1c_zero_keeps: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_sts |=> ((sts_q & $past(sts_q) & ~$past(reg_wdata[5:0]))
                    == ($past(sts_q) & ~$past(reg_wdata[5:0]))))
        else $error("status bit lost on a zero write");

    a_edge_sets: assert property (
        @(posedge core_clk) disable iff (rst)
        (pin_edge != 6'h00) |=> (sts_q & $past(pin_edge)) == $past(pin_edge))
        else $error("pin edge did not set status");

    a_sts_upper_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `OFF_EDGE_STS)
        |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] == $past(sts_q))
        else $error("status read wrong");

    a_rsvd_reads_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `OFF_RSVD_1D) |=> reg_rdata == 8'h00)
        else $error("reserved register read non zero");

    a_force_set: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_fc && reg_wdata[1:0] == 2'b11) |=> fc_q == 2'b11)
        else $error("force bits not set by write");

    a_force_no_sw_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(fc_q[0]) |-> $past(clr_fc0))
        else $error("force bit zero fell without a step");

    a_step_clears: assert property (
        @(posedge core_clk) disable iff (rst)
        (clr_fc1 && !(wr_fc && reg_wdata[1])) |=> !fc_q[1])
        else $error("step with drive one did not clear");

    a_media_flag: assert property (
        @(posedge core_clk) disable iff (rst)
        ##1 media_changed_flag == $past((sel0 & fc_q[0]) | (sel1 & fc_q[1])
                                        | ~sif.lvl[`SYNC_CHG]))
        else $error("media changed flag wrong");

    a_shadow_read: assert property (
        @(posedge core_clk) disable iff (rst)
        (reg_rd && reg_addr == `OFF_RATE_SHADOW)
        |=> reg_rdata == {$past(soft_reset), $past(power_down), 1'b0,
                          $past(write_select_a), $past(data_rate_sel)})
        else $error("shadow read wrong");

    a_set_beats_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_sts && pin_edge[0] && reg_wdata[0]) |=> sts_q[0])
        else $error("clear beat a coincident edge");

    a_force_one_kept: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(fc_q[1]) |-> $past(clr_fc1))
        else $error("force bit one fell without a step");

    a_force_rise_write: assert property (
        @(posedge core_clk) disable iff (rst)
        ($rose(fc_q[0]) || $rose(fc_q[1])) |-> $past(wr_fc))
        else $error("force bit set without a write");

    a_step_clears_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (clr_fc0 && !(wr_fc && reg_wdata[0])) |=> !fc_q[0])
        else $error("step with drive zero did not clear");

    a_step_needs_fall: assert property (
        @(posedge core_clk) disable iff (rst)
        (clr_fc0 || clr_fc1) |-> $past(sif.lvl[`SYNC_STEP]))
        else $error("force bit cleared without a step assertion");

    a_sts_set_by_edge: assert property (
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> (sts_q & ~$past(sts_q) & ~$past(pin_edge)) == 6'h00)
        else $error("status bit set without a pin edge");

    a_media_in_forces: assert property (
        @(posedge core_clk) disable iff (rst)
        !sif.lvl[`SYNC_CHG] |=> media_changed_flag)
        else $error("drive media change did not raise the flag");

    a_rdata_idle_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stood without a read");

    // The interrupt group carries no numbered rule; these guard its contract.
    a_irq_clear_works: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_iclr |=> (irq_sts_q & $past(reg_wdata) & ~$past(irq_ev)) == 8'h00)
        else $error("interrupt status bit did not clear");

    a_irq_force_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (clr_fc0 && fc_q[0]) |=> irq_sts_q[`IRQ_FORCE0])
        else $error("force zero clear raised no interrupt status");

    a_irq_force_one: assert property (
        @(posedge core_clk) disable iff (rst)
        (clr_fc1 && fc_q[1]) |=> irq_sts_q[`IRQ_FORCE1])
        else $error("force one clear raised no interrupt status");

    // An enable write in the same cycle may legally mask the new event.
    a_irq_level: assert property (
        @(posedge core_clk) disable iff (rst)
        ((irq_ev & irq_en_q) != 8'h00 && !wr_ien) |=> irq)
        else $error("enabled event gave no interrupt");

endmodule

`default_nettype wire

// ===== hw/pin_sync.sv
// Two-flop synchroniser and change detector for the monitored pins.
// Assumes raw pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "misc_regs_defines.svh"

module pin_sync
    import misc_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Raw pins
    input wire logic [`SYNC_BITS-1:0] raw,
    // Synchronised view
    pin_sync_if.src sif
);

    logic [`SYNC_BITS-1:0] meta_q;
    logic [`SYNC_BITS-1:0] sync_q;
    logic [`SYNC_BITS-1:0] prev_q;
    // Floppy pins idle high, so they leave reset high to avoid a false step.
    localparam logic [`SYNC_BITS-1:0] sync_rst_lvl = `SYNC_RST_LVL;

    genvar i;
    generate
        for (i = 0; i < `SYNC_BITS; i++) begin : g_bit
            // The first stage feeds only the second stage.
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    meta_q[i] <= sync_rst_lvl[i];
                    sync_q[i] <= sync_rst_lvl[i];
                    prev_q[i] <= sync_rst_lvl[i];
                end else begin
                    meta_q[i] <= raw[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
        end
    endgenerate

    assign sif.lvl = sync_q;
    assign sif.chg = sync_q ^ prev_q;

    a_chg_is_toggle: assert property (
        @(posedge core_clk) disable iff (rst)
        (sif.chg != '0) |-> (sif.lvl ^ $past(sif.lvl)) == sif.chg)
        else $error("change pulse without level change");

endmodule

`default_nettype wire

// ===== include/misc_regs_defines.svh
// Offsets, reset values, field positions and widths of the misc register bank.
// Included by the bank and its pin synchroniser; definitions only.
`ifndef MISC_REGS_DEFINES_SVH
`define MISC_REGS_DEFINES_SVH

`define OFF_EDGE_STS 8'h1c
`define OFF_RSVD_1D 8'h1d
`define OFF_FORCE_CHG 8'h1e
`define OFF_RATE_SHADOW 8'h1f
`define OFF_IRQ_STS 8'h30
`define OFF_IRQ_CLR 8'h31
`define OFF_IRQ_EN 8'h32

`define RST_EDGE_STS 6'h00
`define RST_FORCE_CHG 2'h3
`define RST_IRQ 8'h00

`define EDGE_BITS 6
`define SYNC_BITS 10
`define SYNC_RST_LVL 10'h3c0
`define SYNC_STEP 6
`define SYNC_DS0 7
`define SYNC_DS1 8
`define SYNC_CHG 9

`define IRQ_FORCE0 6
`define IRQ_FORCE1 7

`endif

// ===== include/misc_regs_pkg.sv
// Types shared by the misc register bank and its pin synchroniser.
// Assumes the defines header is compiled alongside.
package misc_regs_pkg;

    typedef logic [7:0] reg_byte_t;

    typedef struct packed {
        logic soft_reset;
        logic power_down;
        logic rsvd;
        logic [2:0] write_select_a;
        logic [1:0] data_rate;
    } rate_shadow_t;

endpackage

// ===== include/pin_sync_if.sv
// Carries synchronised pin levels and their change pulses between modules.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "misc_regs_defines.svh"

interface pin_sync_if;
    logic [`SYNC_BITS-1:0] lvl;
    logic [`SYNC_BITS-1:0] chg;

    modport src (output lvl, output chg);
    modport dst (input lvl, input chg);
endinterface

`default_nettype wire

// ===== testbench/host_model.sv
// Host software model that reaches the bank through its register port.
// Assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

module host_model
    import misc_regs_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand one cycle only, so they are caught just past the edge.
    task automatic rd(input reg_byte_t a, output reg_byte_t d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ===== testbench/misc_regs_tb.sv
// Self-checking bench for the misc register bank slice.
// Assumes the host model drives the register port and the bench the pins.
`timescale 1ns/1ps
`default_nettype none

module misc_regs_tb
    import misc_regs_pkg::*;
;
    logic core_clk, rst, reg_wr, reg_rd, flag, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic step_n, ds0_n, ds1_n, chg_n, pd, sr;
    logic [5:0] gp;
    logic [1:0] rate;
    logic [2:0] wsa;
    reg_byte_t got, v;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    host_model host_model_inst (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    misc_regs misc_regs_inst (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gen_pin_twenty_one(gp[0]), .gen_pin_twenty_two(gp[1]),
        .gen_pin_forty_one(gp[2]), .gen_pin_forty_three(gp[3]),
        .gen_pin_sixty(gp[4]), .gen_pin_sixty_one(gp[5]),
        .head_step_pulse_n(step_n), .drive_zero_select_n(ds0_n),
        .drive_one_select_n(ds1_n), .media_changed_in_n(chg_n),
        .data_rate_sel(rate), .write_select_a(wsa), .power_down(pd),
        .soft_reset(sr), .media_changed_flag(flag), .irq(irq));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results();
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input string n, input reg_byte_t e, input reg_byte_t g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input reg_byte_t a, input reg_byte_t e);
        host_model_inst.rd(a, got);
        chk(n, e, got);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // The step line is moved only on rising edges, like every other input.
    task automatic step_pulse();
        @(posedge core_clk);
        step_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        step_n <= 1'b1;
        cyc(6);
    endtask

    task automatic t_reset();
        rchk("edge_sts", 8'h1c, 8'h00);
        rchk("rsvd_1d", 8'h1d, 8'h00);
        rchk("force", 8'h1e, 8'h03);
        chk("flag", 8'h00, {7'h0, flag});
        chk("irq", 8'h00, {7'h0, irq});
    endtask

    task automatic t_edges();
        v = 8'h00;
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            gp <= gp ^ (6'h01 << i);
            cyc(5);
            v[i] = 1'b1;
            rchk("edge_sts", 8'h1c, v);
        end
        host_model_inst.wr(8'h1c, 8'h00);
        rchk("edge_sts", 8'h1c, 8'h3f);
        host_model_inst.wr(8'h1c, 8'hd5);
        rchk("edge_sts", 8'h1c, 8'h2a);
        host_model_inst.wr(8'h1c, 8'hff);
        @(posedge core_clk);
        gp <= 6'h00;
        cyc(5);
        rchk("edge_sts", 8'h1c, 8'h3f);
        host_model_inst.wr(8'h1d, 8'hff);
        rchk("rsvd_1d", 8'h1d, 8'h00);
        host_model_inst.wr(8'h1c, 8'hff);
        rchk("edge_sts", 8'h1c, 8'h00);
    endtask

    // The pin toggles two edges before the write strobe is driven, so the
    // synchronised edge reaches the status bit in the cycle the clear lands.
    task automatic t_race();
        @(posedge core_clk);
        gp <= gp ^ 6'h01;
        @(posedge core_clk);
        host_model_inst.wr(8'h1c, 8'h01);
        rchk("edge_sts", 8'h1c, 8'h01);
        host_model_inst.wr(8'h1c, 8'h01);
        rchk("edge_sts", 8'h1c, 8'h00);
        host_model_inst.wr(8'h31, 8'hff);
    endtask

    task automatic t_irq();
        host_model_inst.wr(8'h32, 8'h01);
        host_model_inst.wr(8'h31, 8'hff);
        @(posedge core_clk);
        gp <= 6'h01;
        cyc(5);
        chk("irq", 8'h01, {7'h0, irq});
        rchk("irq_sts", 8'h30, 8'h01);
        host_model_inst.wr(8'h32, 8'h00);
        cyc(1);
        chk("irq", 8'h00, {7'h0, irq});
        host_model_inst.wr(8'h31, 8'h01);
        rchk("irq_sts", 8'h30, 8'h00);
        rchk("unmapped", 8'h40, 8'h00);
        host_model_inst.wr(8'h1c, 8'hff);
    endtask

    task automatic t_force();
        host_model_inst.wr(8'h1e, 8'h00);
        rchk("force", 8'h1e, 8'h03);
        @(posedge core_clk);
        ds0_n <= 1'b0;
        cyc(6);
        chk("flag", 8'h01, {7'h0, flag});
        step_pulse();
        rchk("force", 8'h1e, 8'h02);
        chk("flag", 8'h00, {7'h0, flag});
        host_model_inst.wr(8'h1e, 8'h01);
        cyc(3);
        rchk("force", 8'h1e, 8'h03);
        chk("flag", 8'h01, {7'h0, flag});
        @(posedge core_clk);
        ds0_n <= 1'b1;
        ds1_n <= 1'b0;
        step_pulse();
        rchk("force", 8'h1e, 8'h01);
        chk("flag", 8'h00, {7'h0, flag});
        @(posedge core_clk);
        ds1_n <= 1'b1;
        chg_n <= 1'b0;
        cyc(6);
        chk("flag", 8'h01, {7'h0, flag});
        rchk("irq_sts", 8'h30, 8'hc0);
    endtask

    task automatic t_shadow();
        reg_byte_t vals[3] = '{8'hff, 8'h4a, 8'h95};
        foreach (vals[i]) begin
            @(posedge core_clk);
            rate <= vals[i][1:0];
            wsa <= vals[i][4:2];
            pd <= vals[i][6];
            sr <= vals[i][7];
            rchk("shadow", 8'h1f, vals[i] & 8'hdf);
        end
    endtask

    initial begin
        rst = 1'b1;
        gp = 6'h00;
        step_n = 1'b1;
        ds0_n = 1'b1;
        ds1_n = 1'b1;
        chg_n = 1'b1;
        rate = 2'h0;
        wsa = 3'h0;
        pd = 1'b0;
        sr = 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_edges();
        t_irq();
        t_race();
        t_force();
        t_shadow();
        results();
    end
endmodule

`default_nettype wire
